// >>> verilog/psf_servo_top.sv
// PID position servo filter with register port and PWM drive output
`timescale 1ns/1ps
`default_nettype none
// Function
// - Integral adds period times input each sample
// - Raw derivative is sample difference over period
// - Two-sample average halves derivative sum
// - Differentiate feedback only, never command
// - Integrate only at or below switchable velocity threshold
// - Clamp integrator magnitude to programmable limit
// - One new drive value held per sample
// - Four-tap moving average on commanded position
// - Programmable P, I, D gains with defaults
// - Output is P plus I minus D
// - Derivative uses feedback two samples apart
// - Integral adds period times gain times error
// - Programmable offset added before PWM load
module psf_servo_top #(
    parameter int DW = psf_pkg::PSF_DW,
    parameter int AW = psf_pkg::PSF_AW
) (
    input  wire logic                   mclk_in,
    input  wire logic                   reset_in,
    input  wire logic                   ce_in,
    input  wire logic                   sample_strobe_in,
    input  wire logic signed [DW-1:0]   cmd_pos_in,
    input  wire logic signed [DW-1:0]   fb_pos_in,
    input  wire logic [AW-1:0]          reg_addr_in,
    input  wire logic [DW-1:0]          reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic [DW-1:0]               reg_rdata_out,
    output logic [DW-1:0]               pwm_out,
    output logic                        pwm_valid_out,
    output logic                        busy_out
);
    import psf_pkg::*;

    localparam int PW = 2 * DW;

    typedef enum logic [1:0] {S_IDLE, S_CALC1, S_CALC2} psf_state_t;

    // ****************************************
    // Saturation helpers
    // ****************************************
    function automatic logic signed [DW-1:0] sat_dw(input logic signed [PW+1:0] v);
        logic signed [PW+1:0] mx;
        mx = $signed({{(PW+3-DW){1'b0}}, {(DW-1){1'b1}}});
        if (v > mx) begin
            return mx[DW-1:0];
        end else if (v < ~mx) begin
            return ~mx[DW-1:0];
        end
        return v[DW-1:0];
    endfunction

    function automatic logic signed [DW-1:0] scale(input logic signed [PW-1:0] p);
        return sat_dw($signed({{2{p[PW-1]}}, p}) >>> PSF_FRAC);
    endfunction

    // ****************************************
    // State
    // ****************************************
    psf_state_t           st_q, st_d;
    logic signed [DW-1:0] fb_q [PSF_FB_HIST];
    logic signed [DW-1:0] fb_d [PSF_FB_HIST];
    logic signed [DW-1:0] err_q, err_d, vel_q, vel_d;
    logic signed [DW-1:0] integ_q, integ_d, y_q, y_d;
    logic [DW-1:0]        pwm_q, pwm_d, rdata_q, rdata_d;
    logic                 pv_q, pv_d;
    logic                 busy_q, busy_d;
    logic [DW-1:0]        ctrl_q, ctrl_d, kp_q, kp_d, ki_q, ki_d, kd_q, kd_d;
    logic [DW-1:0]        vthr_q, vthr_d, ilim_q, ilim_d, pofs_q, pofs_d;

    logic signed [DW-1:0] p_term, i_step, d_term;
    logic signed [DW:0]   isum, ilim_s, absvel;
    logic signed [DW+1:0] ysum, pwm_sum;
    logic                 gate;

    psf_smooth_if #(.DW(DW)) sm ();

    assign sm.take = ce_in && sample_strobe_in && (st_q == S_IDLE);
    assign sm.cmd  = cmd_pos_in;

    psf_cmd_smoother #(.DW(DW), .TAPS(PSF_TAPS)) u_smooth (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .sm       (sm.smoother)
    );

    // ****************************************
    // Arithmetic of the second step
    // ****************************************
    always_comb begin
        p_term = scale($signed(kp_q) * err_q);
        i_step = scale($signed(ki_q) * err_q);
        d_term = scale($signed(kd_q) * vel_q);
        absvel = vel_q[DW-1] ? -(DW+1)'(vel_q) : (DW+1)'(vel_q);
        gate   = ctrl_q[PSF_CTRL_IEN] && (absvel <= $signed({1'b0, vthr_q}));
        ilim_s = $signed({2'b00, ilim_q[DW-2:0]});
        isum   = (DW+1)'(integ_q) + (DW+1)'(i_step);
    end

    // ****************************************
    // Filter sequence
    // ****************************************
    always_comb begin
        st_d    = st_q;
        fb_d    = fb_q;
        err_d   = err_q;
        vel_d   = vel_q;
        integ_d = integ_q;
        y_d     = y_q;
        pwm_d   = pwm_q;
        pv_d    = 1'b0;
        ysum    = '0;
        pwm_sum = '0;
        case (st_q)
            S_IDLE: begin
                // Strobes seen while busy are dropped, never queued
                if (sample_strobe_in) begin
                    fb_d[0] = fb_pos_in;
                    for (int i = 1; i < PSF_FB_HIST; i++) begin
                        fb_d[i] = fb_q[i-1];
                    end
                    st_d = S_CALC1;
                end
            end
            S_CALC1: begin
                err_d = sat_dw((PW+2)'(sm.avg) - (PW+2)'(fb_q[0]));
                // Raw differences averaged; period folds into the gain
                vel_d = DW'(((DW+1)'(fb_q[0]) - (DW+1)'(fb_q[2])) >>> 1);
                st_d  = S_CALC2;
            end
            S_CALC2: begin
                if (gate) begin
                    if (isum > ilim_s) begin
                        integ_d = DW'(ilim_s);
                    end else if (isum < -ilim_s) begin
                        integ_d = DW'(-ilim_s);
                    end else begin
                        integ_d = DW'(isum);
                    end
                end
                ysum = (DW+2)'(p_term) + (DW+2)'(integ_d) - (DW+2)'(d_term);
                y_d  = sat_dw((PW+2)'(ysum));
                pwm_sum = (DW+2)'(y_d) + $signed({2'b00, pofs_q});
                if (pwm_sum < 0) begin
                    pwm_d = '0;
                end else if (pwm_sum[DW]) begin
                    pwm_d = '1;
                end else begin
                    pwm_d = pwm_sum[DW-1:0];
                end
                pv_d = 1'b1;
                st_d = S_IDLE;
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
        busy_d = (st_d != S_IDLE);
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            st_q    <= S_IDLE;
            err_q   <= '0;
            vel_q   <= '0;
            integ_q <= '0;
            y_q     <= '0;
            pwm_q   <= PSF_RST_POFS;
            pv_q    <= 1'b0;
            busy_q  <= 1'b0;
            for (int i = 0; i < PSF_FB_HIST; i++) begin
                fb_q[i] <= '0;
            end
        end else if (ce_in) begin
            st_q    <= st_d;
            err_q   <= err_d;
            vel_q   <= vel_d;
            integ_q <= integ_d;
            y_q     <= y_d;
            pwm_q   <= pwm_d;
            pv_q    <= pv_d;
            busy_q  <= busy_d;
            fb_q    <= fb_d;
        end
    end

    // ****************************************
    // Register port
    // ****************************************
    always_comb begin
        ctrl_d  = ctrl_q;
        kp_d    = kp_q;
        ki_d    = ki_q;
        kd_d    = kd_q;
        vthr_d  = vthr_q;
        ilim_d  = ilim_q;
        pofs_d  = pofs_q;
        rdata_d = '0;
        if (reg_wr_in) begin
            if (reg_addr_in == PSF_REG_CTRL) begin
                ctrl_d = reg_wdata_in & PSF_RST_CTRL;
            end else if (reg_addr_in == PSF_REG_KP) begin
                kp_d = reg_wdata_in;
            end else if (reg_addr_in == PSF_REG_KI) begin
                ki_d = reg_wdata_in;
            end else if (reg_addr_in == PSF_REG_KD) begin
                kd_d = reg_wdata_in;
            end else if (reg_addr_in == PSF_REG_VTHR) begin
                vthr_d = reg_wdata_in;
            end else if (reg_addr_in == PSF_REG_ILIM) begin
                ilim_d = reg_wdata_in;
            end else if (reg_addr_in == PSF_REG_POFS) begin
                pofs_d = reg_wdata_in;
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in == PSF_REG_CTRL) begin
                rdata_d = ctrl_q;
            end else if (reg_addr_in == PSF_REG_KP) begin
                rdata_d = kp_q;
            end else if (reg_addr_in == PSF_REG_KI) begin
                rdata_d = ki_q;
            end else if (reg_addr_in == PSF_REG_KD) begin
                rdata_d = kd_q;
            end else if (reg_addr_in == PSF_REG_VTHR) begin
                rdata_d = vthr_q;
            end else if (reg_addr_in == PSF_REG_ILIM) begin
                rdata_d = ilim_q;
            end else if (reg_addr_in == PSF_REG_POFS) begin
                rdata_d = pofs_q;
            end else if (reg_addr_in == PSF_REG_INTEG) begin
                rdata_d = integ_q;
            end else if (reg_addr_in == PSF_REG_YOUT) begin
                rdata_d = y_q;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ctrl_q  <= PSF_RST_CTRL;
            kp_q    <= PSF_RST_KP;
            ki_q    <= PSF_RST_KI;
            kd_q    <= PSF_RST_KD;
            vthr_q  <= PSF_RST_VTHR;
            ilim_q  <= PSF_RST_ILIM;
            pofs_q  <= PSF_RST_POFS;
            rdata_q <= '0;
        end else if (ce_in) begin
            ctrl_q  <= ctrl_d;
            kp_q    <= kp_d;
            ki_q    <= ki_d;
            kd_q    <= kd_d;
            vthr_q  <= vthr_d;
            ilim_q  <= ilim_d;
            pofs_q  <= pofs_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign pwm_out       = pwm_q;
    assign pwm_valid_out = pv_q;
    assign busy_out      = busy_q;

    // ****************************************
    // Checks, written for ce_in held high
    // ****************************************
    a_one_calc_per: assert property (@(posedge mclk_in) disable iff (reset_in)
        (sm.take ##1 ce_in ##1 ce_in) |=> pv_q ##1 !pv_q)
        else $error("Strobe did not give exactly one drive value");

    a_pwm_holds: assert property (@(posedge mclk_in) disable iff (reset_in)
        !pv_q |-> $stable(pwm_q))
        else $error("PWM value changed outside a sample update");

    a_integ_limit: assert property (@(posedge mclk_in) disable iff (reset_in)
        (DW+1)'(integ_q) <= ilim_s && (DW+1)'(integ_q) >= -ilim_s)
        else $error("Integrator outside its limit");

    a_integ_gated: assert property (@(posedge mclk_in) disable iff (reset_in)
        (st_q == S_CALC2 && ce_in && !gate) |=> $stable(integ_q))
        else $error("Integrator moved while gated off");

    a_integ_step: assert property (@(posedge mclk_in) disable iff (reset_in)
        (st_q == S_CALC2 && ce_in && gate && isum <= ilim_s && isum >= -ilim_s)
        |=> integ_q == $past(integ_q) + $past(i_step))
        else $error("Integrator did not add its step");

    a_deriv_feedback: assert property (@(posedge mclk_in) disable iff (reset_in)
        (sm.take ##1 ce_in) |=> (DW+2)'(vel_q) ==
            (((DW+2)'($past(fb_pos_in, 2)) - (DW+2)'($past(fb_q[1], 2))) >>> 1))
        else $error("Velocity not taken from feedback two samples apart");

    a_offset_added: assert property (@(posedge mclk_in) disable iff (reset_in)
        (pv_q && y_q > -$signed({1'b0, pofs_q[DW-1:1]}) && y_q < 0)
        |-> pwm_q == DW'((DW+2)'(y_q) + $signed({2'b00, pofs_q})))
        else $error("PWM value is not output plus offset");

    a_reset_clears: assert property (@(posedge mclk_in)
        reset_in |=> integ_q == '0 && fb_q[0] == '0 && st_q == S_IDLE)
        else $error("Reset left filter history set");

    a_read_answer: assert property (@(posedge mclk_in) disable iff (reset_in)
        (ce_in && reg_rd_in && reg_addr_in == PSF_REG_KP && !reg_wr_in) |=> reg_rdata_out == kp_q)
        else $error("Gain read back wrong");
endmodule
`default_nettype wire

// >>> verilog/psf_pkg.sv
// Constants shared by the PID servo filter files
package psf_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int PSF_DW       = 16;
    localparam int PSF_AW       = 4;
    localparam int PSF_FRAC     = 12;
    localparam int PSF_TAPS     = 4;
    localparam int PSF_FB_HIST  = 3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int PSF_CLK_MHZ      = 250;
    localparam int PSF_SAMPLE_US    = 488;
    localparam int PSF_SAMPLE_CYC   = PSF_SAMPLE_US * PSF_CLK_MHZ;
    localparam int PSF_PROFILE_DIV  = 4;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [PSF_AW-1:0] PSF_REG_CTRL   = 4'h0;
    localparam logic [PSF_AW-1:0] PSF_REG_KP     = 4'h1;
    localparam logic [PSF_AW-1:0] PSF_REG_KI     = 4'h2;
    localparam logic [PSF_AW-1:0] PSF_REG_KD     = 4'h3;
    localparam logic [PSF_AW-1:0] PSF_REG_VTHR   = 4'h4;
    localparam logic [PSF_AW-1:0] PSF_REG_ILIM   = 4'h5;
    localparam logic [PSF_AW-1:0] PSF_REG_POFS   = 4'h6;
    localparam logic [PSF_AW-1:0] PSF_REG_INTEG  = 4'h7;
    localparam logic [PSF_AW-1:0] PSF_REG_YOUT   = 4'h8;
    localparam int                PSF_CTRL_IEN   = 0;

    // ****************************************
    // Reset values, gains in signed Q4.12
    // ****************************************
    localparam logic [PSF_DW-1:0] PSF_RST_CTRL   = 16'h0001;
    localparam logic [PSF_DW-1:0] PSF_RST_KP     = 16'h028f;
    localparam logic [PSF_DW-1:0] PSF_RST_KI     = 16'h000a;
    localparam logic [PSF_DW-1:0] PSF_RST_KD     = 16'h20c9;
    localparam logic [PSF_DW-1:0] PSF_RST_VTHR   = 16'h0010;
    localparam logic [PSF_DW-1:0] PSF_RST_ILIM   = 16'h2000;
    localparam logic [PSF_DW-1:0] PSF_RST_POFS   = 16'h8000;
endpackage

// >>> verilog/psf_smooth_if.sv
// Link between the filter core and the command smoother
`timescale 1ns/1ps
`default_nettype none
interface psf_smooth_if #(parameter int DW = psf_pkg::PSF_DW);
    logic                 take;
    logic signed [DW-1:0] cmd;
    logic signed [DW-1:0] avg;
    modport core     (output take, output cmd, input avg);
    modport smoother (input take, input cmd, output avg);
endinterface
`default_nettype wire

// >>> verilog/psf_cmd_smoother.sv
// Four-tap moving average on commanded positions
`timescale 1ns/1ps
`default_nettype none
module psf_cmd_smoother #(
    parameter int DW   = psf_pkg::PSF_DW,
    parameter int TAPS = psf_pkg::PSF_TAPS
) (
    input  wire logic    mclk_in,
    input  wire logic    reset_in,
    psf_smooth_if.smoother sm
);
    import psf_pkg::*;

    logic signed [DW-1:0] tap_q [TAPS];
    logic signed [DW-1:0] tap_d [TAPS];
    logic signed [DW+1:0] sum;

    // ****************************************
    // Shift on each taken sample
    // ****************************************
    always_comb begin
        for (int i = 0; i < TAPS; i++) begin
            tap_d[i] = tap_q[i];
        end
        if (sm.take) begin
            tap_d[0] = sm.cmd;
            for (int i = 1; i < TAPS; i++) begin
                tap_d[i] = tap_q[i-1];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < TAPS; i++) begin
            tap_q[i] <= reset_in ? '0 : tap_d[i];
        end
    end

    // Floor division keeps the average inside the tap range
    always_comb begin
        sum = '0;
        for (int i = 0; i < TAPS; i++) begin
            sum = sum + (DW+2)'(tap_q[i]);
        end
    end
    assign sm.avg = DW'(sum >>> 2);

    a_avg_sum_step: assert property (@(posedge mclk_in) disable iff (reset_in)
        sm.take |=> (sum - $past(sum)) == ((DW+2)'($past(sm.cmd)) - (DW+2)'($past(tap_q[TAPS-1]))))
        else $error("Smoother sum did not step by new minus oldest");
endmodule
`default_nettype wire

// >>> tb/psf_far_model.sv
// Far-side model: profiler, encoder counter and PWM generator latch
`timescale 1ns/1ps
`default_nettype none
module psf_far_model (
    input  wire logic               mclk_in,
    input  wire logic               reset_in,
    input  wire logic               req_in,
    input  wire logic signed [15:0] cmd_in,
    input  wire logic signed [15:0] fb_in,
    input  wire logic [15:0]        pwm_in,
    input  wire logic               pwm_valid_in,
    output logic                    strobe_out,
    output logic signed [15:0]      cmd_out,
    output logic signed [15:0]      fb_out,
    output logic [15:0]             duty_out
);
    logic [1:0] phase_q;

    // ****************************************
    // Sample strobe and position sources
    // ****************************************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            strobe_out <= 1'b0;
            cmd_out    <= 16'sh0000;
            fb_out     <= 16'sh0000;
            phase_q    <= 2'h0;
            duty_out   <= 16'h8000;
        end else begin
            strobe_out <= req_in;
            if (req_in) begin
                fb_out  <= fb_in;
                phase_q <= phase_q + 2'h1;
                // Profiler refreshes only every fourth sample
                if (phase_q == 2'h0) begin
                    cmd_out <= cmd_in;
                end
            end
            // PWM generator loads its duty only on a valid pulse
            if (pwm_valid_in) begin
                duty_out <= pwm_in;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/psf_servo_top_tb.sv
// Self-checking bench for the PID servo filter
`timescale 1ns/1ps
`default_nettype none
module psf_servo_top_tb;
    import psf_pkg::*;
    // ****************************************
    // Signals and reference state
    // ****************************************
    logic               mclk_in      = 1'b0;
    logic               reset_in     = 1'b1;
    logic [3:0]         reg_addr_in  = 4'h0;
    logic [15:0]        reg_wdata_in = 16'h0000;
    logic               reg_wr_in    = 1'b0;
    logic               reg_rd_in    = 1'b0;
    logic               req          = 1'b0;
    logic signed [15:0] cmd_in       = 16'sh0000;
    logic signed [15:0] fb_in        = 16'sh0000;
    logic [15:0]        reg_rdata_out;
    logic [15:0]        pwm_out;
    logic               pwm_valid_out;
    logic               busy_out;
    logic               strobe;
    logic signed [15:0] cmd_pos;
    logic signed [15:0] fb_pos;
    logic [15:0]        duty;
    logic [15:0]        rdv;
    logic [15:0]        rst_tab [9] = '{PSF_RST_CTRL, PSF_RST_KP, PSF_RST_KI, PSF_RST_KD,
        PSF_RST_VTHR, PSF_RST_ILIM, PSF_RST_POFS, 16'h0000, 16'h0000};
    int                 n_mismatch  = 0;
    int                 check_count = 0;
    int                 r_tap [4]   = '{0, 0, 0, 0};
    int                 r_fb [3]    = '{0, 0, 0};
    int                 r_integ     = 0;
    int                 r_y         = 0;
    int                 r_pwm       = 32768;
    int                 r_cnt       = 0;
    int                 r_cmd       = 0;
    int                 r_kp, r_ki, r_kd, r_vthr, r_ilim, r_pofs, r_en;

    psf_servo_top uut (
        .mclk_in          (mclk_in),
        .reset_in         (reset_in),
        .ce_in            (1'b1),
        .sample_strobe_in (strobe),
        .cmd_pos_in       (cmd_pos),
        .fb_pos_in        (fb_pos),
        .reg_addr_in      (reg_addr_in),
        .reg_wdata_in     (reg_wdata_in),
        .reg_wr_in        (reg_wr_in),
        .reg_rd_in        (reg_rd_in),
        .reg_rdata_out    (reg_rdata_out),
        .pwm_out          (pwm_out),
        .pwm_valid_out    (pwm_valid_out),
        .busy_out         (busy_out)
    );
    psf_far_model u_far (
        .mclk_in      (mclk_in),
        .reset_in     (reset_in),
        .req_in       (req),
        .cmd_in       (cmd_in),
        .fb_in        (fb_in),
        .pwm_in       (pwm_out),
        .pwm_valid_in (pwm_valid_out),
        .strobe_out   (strobe),
        .cmd_out      (cmd_pos),
        .fb_out       (fb_pos),
        .duty_out     (duty)
    );

    initial begin
        forever #2 mclk_in = ~mclk_in;
    end

    // ****************************************
    // Checks, bus tasks, reference
    // ****************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_val({15'h0000, got}, {15'h0000, exp});
    endtask
    function automatic int sat(input int v);
        return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task automatic setreg(input logic [3:0] a, input logic [15:0] d);
        wr(a, d);
        case (a)
            PSF_REG_CTRL: r_en = d[0];
            PSF_REG_KP:   r_kp = int'($signed(d));
            PSF_REG_KI:   r_ki = int'($signed(d));
            PSF_REG_KD:   r_kd = int'($signed(d));
            PSF_REG_VTHR: r_vthr = d;
            PSF_REG_ILIM: r_ilim = d[14:0];
            PSF_REG_POFS: r_pofs = d;
            default: ;
        endcase
    endtask
    task automatic ref_step(input int f);
        int avg, err, vel, st;
        for (int i = 3; i > 0; i--) r_tap[i] = r_tap[i-1];
        r_tap[0] = r_cmd;
        r_fb[2] = r_fb[1];
        r_fb[1] = r_fb[0];
        r_fb[0] = f;
        avg = (r_tap[0] + r_tap[1] + r_tap[2] + r_tap[3]) >>> 2;
        err = sat(avg - r_fb[0]);
        vel = (r_fb[0] - r_fb[2]) >>> 1;
        st = sat((r_ki * err) >>> 12);
        if (r_en != 0 && ((vel < 0) ? -vel : vel) <= r_vthr) begin
            r_integ = r_integ + st;
            r_integ = (r_integ > r_ilim) ? r_ilim : r_integ;
            r_integ = (r_integ < -r_ilim) ? -r_ilim : r_integ;
        end
        r_y = sat(sat((r_kp * err) >>> 12) + r_integ - sat((r_kd * vel) >>> 12));
        r_pwm = r_y + r_pofs;
        r_pwm = (r_pwm > 65535) ? 65535 : ((r_pwm < 0) ? 0 : r_pwm);
    endtask
    // One sample; dup keeps the strobe up a second cycle while busy
    task automatic sample(input int c, input int f, input bit dup);
        int n;
        @(posedge mclk_in);
        req    <= 1'b1;
        cmd_in <= 16'(c);
        fb_in  <= 16'(f);
        r_cmd = (r_cnt == 0) ? c : r_cmd;
        r_cnt = (r_cnt + 1) % 4;
        ref_step(f);
        if (dup) begin
            @(posedge mclk_in);
            r_cmd = (r_cnt == 0) ? c : r_cmd;
            r_cnt = (r_cnt + 1) % 4;
        end
        @(posedge mclk_in);
        req <= 1'b0;
        @(posedge mclk_in);
        for (n = 1; n < 12; n++) begin
            @(posedge mclk_in);
            #1;
            if (pwm_valid_out === 1'b1) break;
        end
        check_val(16'(n), dup ? 16'h0001 : 16'h0002);
        check_val(pwm_out, 16'(r_pwm));
        @(posedge mclk_in);
        #1 check_bit(pwm_valid_out, 1'b0);
        check_val(duty, 16'(r_pwm));
        rd(PSF_REG_YOUT, rdv);
        check_val(rdv, 16'(r_y));
        rd(PSF_REG_INTEG, rdv);
        check_val(rdv, 16'(r_integ));
        check_val(pwm_out, 16'(r_pwm));
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_mismatch++;
        test_done();
    end
    initial begin
        r_en = 1;
        r_kp = int'($signed(PSF_RST_KP));
        r_ki = int'($signed(PSF_RST_KI));
        r_kd = int'($signed(PSF_RST_KD));
        r_vthr = PSF_RST_VTHR;
        r_ilim = PSF_RST_ILIM[14:0];
        r_pofs = PSF_RST_POFS;
        repeat (12) @(posedge mclk_in);
        reset_in <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            rd(4'(a), rdv);
            check_val(rdv, rst_tab[a]);
        end
        rd(4'hf, rdv);
        check_val(rdv, 16'h0000);
        @(posedge mclk_in);
        #1 check_val(reg_rdata_out, 16'h0000);
        check_val(pwm_out, 16'h8000);
        check_bit(busy_out, 1'b0);
        $display("test reset_values done");
        setreg(PSF_REG_CTRL, 16'hffff);
        rd(PSF_REG_CTRL, rdv);
        check_val(rdv, 16'h0001);
        setreg(PSF_REG_KP, 16'h0400);
        rd(PSF_REG_KP, rdv);
        check_val(rdv, 16'h0400);
        wr(4'hc, 16'h5a5a);
        wr(PSF_REG_INTEG, 16'h1234);
        rd(4'hc, rdv);
        check_val(rdv, 16'h0000);
        rd(PSF_REG_INTEG, rdv);
        check_val(rdv, 16'h0000);
        $display("test registers done");
        for (int i = 0; i < 8; i++) sample(400, 0, 0);
        $display("test command_step done");
        for (int i = 1; i < 7; i++) sample(400, i * 100, 0);
        $display("test feedback_ramp done");
        setreg(PSF_REG_ILIM, 16'h8040);
        setreg(PSF_REG_KI, 16'h1000);
        for (int i = 0; i < 6; i++) sample(400, 600, 0);
        $display("test integrator_limit done");
        setreg(PSF_REG_CTRL, 16'h0000);
        for (int i = 0; i < 3; i++) sample(-300, 600, 0);
        $display("test integrator_switch done");
        sample(-300, 600, 1);
        sample(-300, 600, 1);
        $display("test busy_refusal done");
        for (int i = 0; i < 4; i++) sample(28672, -28672, 0);
        for (int i = 0; i < 4; i++) sample(-28672, 28672, 0);
        $display("test saturation done");
        test_done();
    end
endmodule
`default_nettype wire
